/* File: hw/lirq_pkg.sv */
// Shared constants for the local interrupt routing and quiet timer block.
package lirq_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NCORE  = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SEL_W  = 3;
    localparam int PERF_W = 8;
    localparam int KEY_W  = 8;
    localparam int LOAD_W = 20;
    localparam int CNT_W  = 24;
    localparam int EV_W   = 3;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_BERR   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_PSET   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_PCLR   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_TROUTE = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_QUIET  = 8'h30;
    localparam logic [ADDR_W-1:0] OFF_ISTAT  = 8'h80;
    localparam logic [ADDR_W-1:0] OFF_IMASK  = 8'h84;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_BERR_MASK_BIT = 6;
    localparam int BERR_SEL_LSB       = 4;
    localparam int PERF_NORM_LSB      = 0;
    localparam int PERF_FAST_LSB      = 4;
    localparam int TROUTE_SEL_LSB     = 0;
    localparam int TROUTE_KEY_LSB     = 24;
    localparam int QUIET_EN_BIT       = 20;
    localparam int QUIET_LOAD_LSB     = 0;
    localparam int EV_BERR            = 0;
    localparam int EV_QUIET           = 1;
    localparam int EV_KEY             = 2;

    // ------------------------------------------------------------------
    // Values and reset values
    // ------------------------------------------------------------------
    localparam logic [KEY_W-1:0]  TROUTE_KEY_VAL = 8'h01;
    localparam logic [3:0]        QUIET_TAIL     = 4'hf;
    localparam logic [SEL_W-1:0]  RST_SEL        = 3'h0;
    localparam logic [PERF_W-1:0] RST_PERF       = 8'h00;
    localparam logic [KEY_W-1:0]  RST_KEY        = 8'h00;
    localparam logic [LOAD_W-1:0] RST_LOAD       = 20'h00000;
    localparam logic [CNT_W-1:0]  RST_CNT        = 24'h000000;
    localparam logic [EV_W-1:0]   RST_EV         = 3'h0;

endpackage : lirq_pkg

/* File: hw/lirq_route_dec.sv */
// Decoder from a 3-bit core selector to per-core normal and fast lines.
`timescale 1ns/1ps
module lirq_route_dec (
    input  wire logic [lirq_pkg::SEL_W-1:0] i_sel,    // Route selector.
    input  wire logic                       i_req,    // Request to route.
    output logic      [lirq_pkg::NCORE-1:0] o_normal, // Normal lines.
    output logic      [lirq_pkg::NCORE-1:0] o_fast    // Fast lines.
);
    import lirq_pkg::*;

    // Values 0..3 pick a normal line, 4..7 the fast line of the same core.
    for (genvar n = 0; n < NCORE; n++) begin : g_core
        always_comb begin
            o_normal[n] = i_req && !i_sel[2] && (i_sel[1:0] == 2'(n));
            o_fast[n]   = i_req &&  i_sel[2] && (i_sel[1:0] == 2'(n));
        end
    end

endmodule : lirq_route_dec

/* File: hw/lirq_quiet_timer.sv */
// Bus quiet-time counter with reload while transactions are outstanding.
`timescale 1ns/1ps
module lirq_quiet_timer (
    input  wire logic                        i_core_clk, // Clock.
    input  wire logic                        i_srst,     // Sync reset.
    input  wire logic                        i_ce,       // Clock enable.
    input  wire logic                        i_busy,     // Outstanding txn.
    input  wire logic [lirq_pkg::LOAD_W-1:0] i_load,     // Load value.
    output logic                             o_zero      // Counter at zero.
);
    import lirq_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        if (i_busy) begin
            cnt_d = {i_load, QUIET_TAIL};
        end else if (cnt_q != RST_CNT) begin
            cnt_d = cnt_q - CNT_W'(1);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            cnt_q <= RST_CNT;
        end else if (i_ce) begin
            cnt_q <= cnt_d;
        end
    end

    assign o_zero = (cnt_q == RST_CNT);

    sequence s_idle_at_zero;
        o_zero && !i_busy && i_ce;
    endsequence

    a_quiet_reload: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        (i_busy && i_ce) |=> (cnt_q == {$past(i_load), QUIET_TAIL}))
        else $error("quiet counter not reloaded");

    a_quiet_count: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        (!i_busy && i_ce && !o_zero) |=> (cnt_q == $past(cnt_q) - 24'h1))
        else $error("quiet counter did not decrement");

    a_quiet_hold: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        s_idle_at_zero |=> o_zero)
        else $error("quiet counter left zero without traffic");

endmodule : lirq_quiet_timer

/* File: hw/lirq_top.sv */
// Local interrupt routing, performance monitor routing and quiet timer.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module lirq_top (
    input  wire logic                        i_core_clk,    // 125 MHz clock.
    input  wire logic                        i_srst,        // Sync reset.
    input  wire logic                        i_ce,          // Clock enable.
    input  wire logic [lirq_pkg::ADDR_W-1:0] i_addr,        // Byte address.
    input  wire logic [lirq_pkg::DATA_W-1:0] i_wdata,       // Write data.
    input  wire logic                        i_wr,          // Write strobe.
    input  wire logic                        i_rd,          // Read strobe.
    output logic      [lirq_pkg::DATA_W-1:0] o_rdata,       // Read data.
    input  wire logic                        i_bus_err,     // Bus error.
    input  wire logic [lirq_pkg::NCORE-1:0]  i_perf_monitor_request, // Perf.
    input  wire logic                        i_timer_req,   // Local timer.
    input  wire logic                        i_axi_busy,    // Txn pending.
    output logic      [lirq_pkg::NCORE-1:0]  o_core_normal, // Normal lines.
    output logic      [lirq_pkg::NCORE-1:0]  o_core_fast,   // Fast lines.
    output logic                             o_irq          // Event irq.
);
    import lirq_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic                  bus_error_irq_mask_q, bus_error_irq_mask_d;
    logic [SEL_W-1:0]      berr_sel_q,           berr_sel_d;
    logic [PERF_W-1:0]     perf_q,               perf_d;
    logic [SEL_W-1:0]      tmr_sel_q,            tmr_sel_d;
    logic [KEY_W-1:0]      tmr_key_q,            tmr_key_d;
    logic                  quiet_irq_enable_q,   quiet_irq_enable_d;
    logic [LOAD_W-1:0]     quiet_load_q,         quiet_load_d;
    logic [EV_W-1:0]       ev_q,                 ev_d;
    logic [EV_W-1:0]       ev_mask_q,            ev_mask_d;
    logic [DATA_W-1:0]     rdata_q,              rdata_d;
    logic [NCORE-1:0]      norm_q,               norm_d;
    logic [NCORE-1:0]      fast_q,               fast_d;
    logic                  berr_live_q,          quiet_irq_q;

    logic                  wr_ctrl, wr_berr, wr_pset, wr_pclr;
    logic                  wr_troute, wr_quiet, wr_istat, wr_imask;
    logic                  key_ok;
    logic [KEY_W-1:0]      wkey;
    logic [PERF_W-1:0]     wperf;
    logic [EV_W-1:0]       ev_set;

    logic                  berr_live;
    logic [NCORE-1:0]      berr_norm, berr_fast;
    logic [NCORE-1:0]      tmr_norm,  tmr_fast;
    logic [NCORE-1:0]      perf_norm_mask, perf_fast_mask;
    logic [NCORE-1:0]      perf_norm, perf_fast;
    logic                  quiet_zero, quiet_irq;
    logic [NCORE-1:0]      perf_both;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    always_comb begin
        wr_ctrl   = i_wr && (i_addr == OFF_CTRL);
        wr_berr   = i_wr && (i_addr == OFF_BERR);
        wr_pset   = i_wr && (i_addr == OFF_PSET);
        wr_pclr   = i_wr && (i_addr == OFF_PCLR);
        wr_troute = i_wr && (i_addr == OFF_TROUTE);
        wr_quiet  = i_wr && (i_addr == OFF_QUIET);
        wr_istat  = i_wr && (i_addr == OFF_ISTAT);
        wr_imask  = i_wr && (i_addr == OFF_IMASK);
        wkey      = i_wdata[TROUTE_KEY_LSB +: KEY_W];
        wperf     = i_wdata[PERF_W-1:0];
        key_ok    = (wkey == TROUTE_KEY_VAL);
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_comb begin
        bus_error_irq_mask_d = bus_error_irq_mask_q;
        berr_sel_d           = berr_sel_q;
        perf_d               = perf_q;
        tmr_sel_d            = tmr_sel_q;
        tmr_key_d            = tmr_key_q;
        quiet_irq_enable_d   = quiet_irq_enable_q;
        quiet_load_d         = quiet_load_q;
        ev_mask_d            = ev_mask_q;
        if (wr_ctrl) begin
            bus_error_irq_mask_d = i_wdata[CTRL_BERR_MASK_BIT];
        end
        if (wr_berr) begin
            berr_sel_d = i_wdata[BERR_SEL_LSB +: SEL_W];
        end
        if (wr_pset) begin
            perf_d = perf_q | wperf;
        end
        if (wr_pclr) begin
            perf_d = perf_q & ~wperf;
        end
        if (wr_troute) begin
            tmr_key_d = wkey;
            if (key_ok) begin
                tmr_sel_d = i_wdata[TROUTE_SEL_LSB +: SEL_W];
            end
        end
        if (wr_quiet) begin
            quiet_irq_enable_d = i_wdata[QUIET_EN_BIT];
            quiet_load_d       = i_wdata[QUIET_LOAD_LSB +: LOAD_W];
        end
        if (wr_imask) begin
            ev_mask_d = i_wdata[EV_W-1:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            bus_error_irq_mask_q <= 1'b0;
            berr_sel_q           <= RST_SEL;
            perf_q               <= RST_PERF;
            tmr_sel_q            <= RST_SEL;
            tmr_key_q            <= RST_KEY;
            quiet_irq_enable_q   <= 1'b0;
            quiet_load_q         <= RST_LOAD;
            ev_mask_q            <= RST_EV;
        end else if (i_ce) begin
            bus_error_irq_mask_q <= bus_error_irq_mask_d;
            berr_sel_q           <= berr_sel_d;
            perf_q               <= perf_d;
            tmr_sel_q            <= tmr_sel_d;
            tmr_key_q            <= tmr_key_d;
            quiet_irq_enable_q   <= quiet_irq_enable_d;
            quiet_load_q         <= quiet_load_d;
            ev_mask_q            <= ev_mask_d;
        end
    end

    // ------------------------------------------------------------------
    // Request routing
    // ------------------------------------------------------------------
    assign berr_live = i_bus_err && !bus_error_irq_mask_q;

    lirq_route_dec u_berr_dec (
        .i_sel    (berr_sel_q),
        .i_req    (berr_live),
        .o_normal (berr_norm),
        .o_fast   (berr_fast)
    );

    lirq_route_dec u_tmr_dec (
        .i_sel    (tmr_sel_q),
        .i_req    (i_timer_req),
        .o_normal (tmr_norm),
        .o_fast   (tmr_fast)
    );

    lirq_quiet_timer u_quiet (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_ce       (i_ce),
        .i_busy     (i_axi_busy),
        .i_load     (quiet_load_q),
        .o_zero     (quiet_zero)
    );

    assign quiet_irq      = quiet_zero && quiet_irq_enable_q;
    assign perf_norm_mask = perf_q[PERF_NORM_LSB +: NCORE];
    assign perf_fast_mask = perf_q[PERF_FAST_LSB +: NCORE];

    for (genvar n = 0; n < NCORE; n++) begin : g_perf
        always_comb begin
            perf_fast[n] = i_perf_monitor_request[n]
                           && perf_fast_mask[n];
            perf_norm[n] = i_perf_monitor_request[n]
                           && perf_norm_mask[n]
                           && !perf_fast_mask[n];
        end
    end

    always_comb begin
        norm_d    = berr_norm | tmr_norm | perf_norm;
        norm_d[0] = norm_d[0] | quiet_irq;
        fast_d    = berr_fast | tmr_fast | perf_fast;
    end

    // ------------------------------------------------------------------
    // Event status and interrupt
    // ------------------------------------------------------------------
    always_comb begin
        ev_set           = RST_EV;
        ev_set[EV_BERR]  = berr_live && !berr_live_q;
        ev_set[EV_QUIET] = quiet_irq && !quiet_irq_q;
        ev_set[EV_KEY]   = wr_troute && !key_ok;
        ev_d = ev_q;
        if (wr_istat) begin
            ev_d = ev_q & ~i_wdata[EV_W-1:0];
        end
        ev_d = ev_d | ev_set;
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        rdata_d = '0;
        if (i_rd) begin
            case (i_addr)
                OFF_CTRL: begin
                    rdata_d[CTRL_BERR_MASK_BIT] = bus_error_irq_mask_q;
                end
                OFF_BERR: begin
                    rdata_d[BERR_SEL_LSB +: SEL_W] = berr_sel_q;
                end
                OFF_PSET, OFF_PCLR: begin
                    rdata_d[PERF_W-1:0] = perf_q;
                end
                OFF_TROUTE: begin
                    rdata_d[TROUTE_KEY_LSB +: KEY_W] = tmr_key_q;
                    rdata_d[TROUTE_SEL_LSB +: SEL_W] = tmr_sel_q;
                end
                OFF_QUIET: begin
                    rdata_d[QUIET_EN_BIT]              = quiet_irq_enable_q;
                    rdata_d[QUIET_LOAD_LSB +: LOAD_W]  = quiet_load_q;
                end
                OFF_ISTAT: begin
                    rdata_d[EV_W-1:0] = ev_q;
                end
                OFF_IMASK: begin
                    rdata_d[EV_W-1:0] = ev_mask_q;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Output and status registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ev_q        <= RST_EV;
            rdata_q     <= '0;
            norm_q      <= '0;
            fast_q      <= '0;
            berr_live_q <= 1'b0;
            quiet_irq_q <= 1'b0;
        end else if (i_ce) begin
            ev_q        <= ev_d;
            rdata_q     <= rdata_d;
            norm_q      <= norm_d;
            fast_q      <= fast_d;
            berr_live_q <= berr_live;
            quiet_irq_q <= quiet_irq;
        end
    end

    assign o_rdata       = rdata_q;
    assign o_core_normal = norm_q;
    assign o_core_fast   = fast_q;
    assign o_irq         = |(ev_q & ev_mask_q);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);

    sequence s_key_bad_write;
        i_ce && wr_troute && !key_ok;
    endsequence

    sequence s_quiet_fire;
        i_ce && quiet_zero && quiet_irq_enable_q;
    endsequence

    // Requests with both masks set and no other source on that normal line.
    assign perf_both = i_perf_monitor_request & perf_fast_mask
                       & perf_norm_mask & ~(berr_norm | tmr_norm)
                       & ~{{(NCORE-1){1'b0}}, quiet_irq};

    a_berr_normal_route: assert property (
        (i_ce && i_bus_err && !bus_error_irq_mask_q && !berr_sel_q[2])
        |=> o_core_normal[$past(berr_sel_q[1:0])])
        else $error("bus error missed its normal line");

    a_berr_fast_route: assert property (
        (i_ce && i_bus_err && !bus_error_irq_mask_q && berr_sel_q[2])
        |=> o_core_fast[$past(berr_sel_q[1:0])])
        else $error("bus error missed its fast line");

    a_berr_mask_holds: assert property (
        (i_ce && bus_error_irq_mask_q && !ev_q[EV_BERR])
        |=> !ev_q[EV_BERR])
        else $error("masked bus error raised an event");

    a_perf_set_ones: assert property (
        (i_ce && wr_pset)
        |=> ((perf_q & $past(wperf)) == $past(wperf)))
        else $error("set alias failed to set bits");

    a_perf_clr_ones: assert property (
        (i_ce && wr_pclr)
        |=> ((perf_q & $past(wperf)) == 8'h00))
        else $error("clear alias failed to clear bits");

    a_perf_fast_line: assert property (
        (i_ce && |(i_perf_monitor_request & perf_fast_mask))
        |=> ((o_core_fast & $past(i_perf_monitor_request & perf_fast_mask))
             == $past(i_perf_monitor_request & perf_fast_mask)))
        else $error("perf request missed fast line");

    a_perf_fast_wins: assert property (
        (i_ce && |perf_both)
        |=> (((o_core_fast & $past(perf_both)) == $past(perf_both))
             && ((o_core_normal & $past(perf_both)) == 4'h0)))
        else $error("perf request drove both lines");

    a_key_guard: assert property (
        s_key_bad_write |=> ($stable(tmr_sel_q) && ev_q[EV_KEY]))
        else $error("timer route changed without key");

    a_quiet_core0: assert property (
        s_quiet_fire |=> o_core_normal[0] ##1 (o_core_normal[0] || !i_ce
            || !quiet_irq_q || i_axi_busy || $past(wr_quiet)))
        else $error("quiet interrupt not on core zero normal line");

    a_quiet_withheld: assert property (
        (i_ce && !quiet_irq_enable_q && !berr_norm[0] && !tmr_norm[0]
         && !(i_perf_monitor_request[0] && perf_norm_mask[0]))
        |=> !o_core_normal[0])
        else $error("quiet interrupt raised while disabled");

    a_irq_level: assert property (
        (i_ce && wr_istat && (ev_set == RST_EV)
         && ((ev_q & ev_mask_q & ~i_wdata[EV_W-1:0]) == RST_EV))
        |=> !o_irq)
        else $error("interrupt stayed up after status clear");

endmodule : lirq_top

/* File: tb/lirq_axi_model.sv */
// Bus traffic model that holds the outstanding-transaction flag.
`timescale 1ns/1ps
module lirq_axi_model (
    input  wire logic       i_core_clk, // Clock.
    input  wire logic       i_srst,     // Sync reset.
    input  wire logic       i_start,    // Begin a burst of traffic.
    input  wire logic [7:0] i_len,      // Cycles of outstanding traffic.
    output logic            o_busy      // Transaction outstanding.
);
    logic [7:0] left_q;
    logic [7:0] left_d;
    always_comb begin
        left_d = left_q;
        if (i_start) begin
            left_d = i_len;
        end else if (left_q != 8'h00) begin
            left_d = left_q - 8'h01;
        end
    end
    always_ff @(posedge i_core_clk) begin
        left_q <= i_srst ? 8'h00 : left_d;
    end
    assign o_busy = (left_q != 8'h00);
endmodule : lirq_axi_model

/* File: tb/lirq_top_tb.sv */
// Self-checking bench for the local interrupt routing block.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module lirq_top_tb;
    import lirq_pkg::*;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        berr;
        logic [3:0]  perf;
        logic        tmr;
        logic [3:0]  nrm;
        logic [3:0]  fst;
    } lirq_row_type;
    logic        clk = 1'b0;
    logic        i_srst = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_bus_err = 1'b0;
    logic [3:0]  i_perf = 4'h0;
    logic        i_tmr = 1'b0;
    logic        start = 1'b0;
    logic        ce = 1'b1;
    logic        busy;
    logic [31:0] o_rdata;
    logic [3:0]  o_nrm;
    logic [3:0]  o_fst;
    logic        o_irq;
    logic [31:0] rv;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cycles = 0;
    lirq_row_type rows [12] = '{
        '{8'h0c, 32'h00, 1'b1, 4'h0, 1'b0, 4'h1, 4'h0},
        '{8'h0c, 32'h20, 1'b1, 4'h0, 1'b0, 4'h4, 4'h0},
        '{8'h0c, 32'h70, 1'b1, 4'h0, 1'b0, 4'h0, 4'h8},
        '{8'h00, 32'h40, 1'b1, 4'h0, 1'b0, 4'h0, 4'h0},
        '{8'h00, 32'h00, 1'b0, 4'h0, 1'b0, 4'h0, 4'h0},
        '{8'h24, 32'h01000005, 1'b0, 4'h0, 1'b1, 4'h0, 4'h2},
        '{8'h24, 32'h01000003, 1'b0, 4'h0, 1'b1, 4'h8, 4'h0},
        '{8'h24, 32'h02000006, 1'b0, 4'h0, 1'b1, 4'h8, 4'h0},
        '{8'h24, 32'h01000000, 1'b0, 4'h0, 1'b0, 4'h0, 4'h0},
        '{8'h10, 32'h11, 1'b0, 4'h1, 1'b0, 4'h0, 4'h1},
        '{8'h14, 32'h10, 1'b0, 4'h1, 1'b0, 4'h1, 4'h0},
        '{8'h10, 32'h80, 1'b0, 4'h9, 1'b0, 4'h1, 4'h8}};
    logic [7:0]  regs [6] = '{8'h00, 8'h0c, 8'h10, 8'h14, 8'h24, 8'h30};

    lirq_top u_dut (
        .i_core_clk             (clk),
        .i_srst                 (i_srst),
        .i_ce                   (ce),
        .i_addr                 (i_addr),
        .i_wdata                (i_wdata),
        .i_wr                   (i_wr),
        .i_rd                   (i_rd),
        .o_rdata                (o_rdata),
        .i_bus_err              (i_bus_err),
        .i_perf_monitor_request (i_perf),
        .i_timer_req            (i_tmr),
        .i_axi_busy             (busy),
        .o_core_normal          (o_nrm),
        .o_core_fast            (o_fst),
        .o_irq                  (o_irq)
    );
    lirq_axi_model u_axi (
        .i_core_clk (clk),
        .i_srst     (i_srst),
        .i_start    (start),
        .i_len      (8'h0a),
        .o_busy     (busy)
    );

    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (10) @(posedge clk);
        i_srst <= 1'b0;
        foreach (regs[k]) begin
            rd(regs[k], rv);
            `CHK(rv, 32'h0)
        end
        wr(8'h0c, 32'hffffffff);
        rd(8'h0c, rv);
        `CHK(rv, 32'h70)
        rd(8'h04, rv);
        `CHK(rv, 32'h0)
        $display("reset and readback done");
        foreach (rows[k]) begin
            wr(rows[k].addr, rows[k].wdata);
            i_bus_err <= rows[k].berr;
            i_perf <= rows[k].perf;
            i_tmr <= rows[k].tmr;
            settle(3);
            `CHK({o_nrm, o_fst}, {rows[k].nrm, rows[k].fst})
        end
        $display("routing table done");
        rd(8'h10, rv);
        `CHK(rv, 32'h81)
        rd(8'h14, rv);
        `CHK(rv, 32'h81)
        rd(OFF_ISTAT, rv);
        `CHK(rv, 32'h5)
        wr(OFF_IMASK, 32'h4);
        settle(2);
        `CHK(o_irq, 1'b1)
        wr(OFF_ISTAT, 32'h4);
        settle(2);
        `CHK(o_irq, 1'b0)
        wr(OFF_CTRL, 32'h40);
        wr(OFF_ISTAT, 32'h7);
        i_bus_err <= 1'b1;
        settle(3);
        rd(OFF_ISTAT, rv);
        `CHK(rv, 32'h0)
        i_bus_err <= 1'b0;
        @(posedge clk);
        ce <= 1'b0;
        wr(OFF_PSET, 32'hff);
        ce <= 1'b1;
        rd(OFF_PSET, rv);
        `CHK(rv, 32'h81)
        $display("interrupt status done");
        i_perf <= 4'h0;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        wr(OFF_QUIET, 32'h00100001);
        for (int w = 0; w < 50 && busy === 1'b1; w++) begin
            @(posedge clk);
        end
        settle(30);
        `CHK(o_nrm[0], 1'b0)
        settle(1);
        `CHK({o_nrm, o_fst}, 8'h10)
        settle(10);
        `CHK(o_nrm[0], 1'b1)
        wr(OFF_QUIET, 32'h00000001);
        settle(3);
        `CHK(o_nrm[0], 1'b0)
        $display("quiet timer done");
        report_and_stop();
    end
endmodule : lirq_top_tb
